// *** rtl/cpu_sub_pkg.sv ***
package cpu_sub_pkg;

  // opcodes handled by this slice of the core
  localparam logic [7:0] OPC_SELECT_LOWER_BANK = 8'h4f;
  localparam logic [7:0] OPC_SELECT_UPPER_BANK = 8'h5f;
  localparam logic [7:0] OPC_FORCE_CARRY = 8'hdf;
  localparam logic [7:0] OPC_SHIFT_REG = 8'hd0;
  localparam logic [7:0] OPC_SHIFT_IND = 8'hd1;
  localparam logic [7:0] OPC_SET_WINDOW = 8'h31;
  localparam logic [7:0] OPC_STOP = 8'h7f;
  localparam logic [3:0] OPC_HI_SUB = 4'h2;
  localparam logic [3:0] OPC_HI_SUB_BORROW = 4'h3;

  // addressing-form codes in the low opcode nibble of the subtract groups
  localparam logic [3:0] FORM_FIRST = 4'h2;
  localparam logic [3:0] FORM_REG_IND = 4'h3;
  localparam logic [3:0] FORM_LAST = 4'h6;

  // instruction length and timing
  localparam logic [1:0] BYTES_ONE = 2'h1;
  localparam logic [1:0] BYTES_TWO = 2'h2;
  localparam logic [1:0] BYTES_THREE = 2'h3;
  localparam logic [2:0] CYC_SHORT = 3'h4;
  localparam logic [2:0] CYC_LONG = 3'h6;
  localparam logic [2:0] CYC_NONE = 3'h1;

  // flag bit positions
  localparam int FLAG_C = 7;
  localparam int FLAG_Z = 6;
  localparam int FLAG_S = 5;
  localparam int FLAG_V = 4;
  localparam int FLAG_D = 3;
  localparam int FLAG_H = 2;
  localparam int FLAG_BANK = 0;

  // window pointer field: bits 7..3 are the base, bit 3 splits the pair
  localparam int PTR_SPLIT_BIT = 3;

  // register port offsets
  localparam logic [3:0] REG_FLAGS = 4'h0;
  localparam logic [3:0] REG_PTR0 = 4'h1;
  localparam logic [3:0] REG_PTR1 = 4'h2;
  localparam logic [3:0] REG_STATUS = 4'h3;

  // status register fields
  localparam int STAT_STOP = 7;
  localparam int STAT_BUSY = 6;

  // reset values
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [7:0] PTR0_RST = 8'h00;
  localparam logic [7:0] PTR1_RST = 8'h08;

  typedef enum logic [1:0] {ST_READY, ST_BUSY, ST_STOPPED} run_state_t;

endpackage : cpu_sub_pkg

// *** rtl/alu_if.sv ***
`timescale 1ns/10ps
interface alu_if;
  logic [7:0] opcode;
  logic [7:0] dst;
  logic [7:0] src;
  logic carry_in;
  logic [7:0] result;
  logic c;
  logic z;
  logic s;
  logic v;
  logic h;

  modport core (output opcode, output dst, output src, output carry_in,
    input result, input c, input z, input s, input v, input h);
  modport alu (input opcode, input dst, input src, input carry_in,
    output result, output c, output z, output s, output v, output h);
endinterface : alu_if

// *** rtl/sub_shift_alu.sv ***
`timescale 1ns/10ps
module sub_shift_alu
  import cpu_sub_pkg::*;
(
  alu_if.alu a
);

  // subtraction is done as dst + ~src + 1 - borrow, the way the datapath adder sees it
  wire is_sbc = (a.opcode[7:4] == OPC_HI_SUB_BORROW);
  wire borrow_in = is_sbc & a.carry_in;
  wire [8:0] add_in = {8'h00, ~borrow_in};
  wire [8:0] sum = {1'b0, a.dst} + {1'b0, ~a.src} + add_in;
  wire [4:0] nib_in = {4'h0, ~borrow_in};
  wire [4:0] nib = {1'b0, a.dst[3:0]} + {1'b0, ~a.src[3:0]} + nib_in;
  wire is_shift = (a.opcode == OPC_SHIFT_REG) || (a.opcode == OPC_SHIFT_IND);

  // sign bit stays and is copied down, bit 0 falls into carry
  wire [7:0] shift_res = {a.dst[7], a.dst[7:1]};

  // no carry out of the adder means a borrow happened
  wire sub_c = ~sum[8];
  wire sub_v = (a.dst[7] != a.src[7]) && (sum[7] == a.src[7]);
  wire sub_h = ~nib[4];

  // shift results beat subtraction results when the opcode is a shift, except h, which always carries the subtract nibble borrow
  assign a.result = is_shift ? shift_res : sum[7:0];
  assign a.c = is_shift ? a.dst[0] : sub_c;
  assign a.z = (a.result == 8'h00);
  assign a.s = a.result[7];
  assign a.v = is_shift ? 1'b0 : sub_v;
  assign a.h = sub_h;

endmodule : sub_shift_alu

// *** rtl/cpu_sub_shift_ptr.sv ***
// The implementer's own choices: strobed register access and the placing of the registers.
`timescale 1ns/10ps
// Contract
// - opcode 5F sets bank flag, arithmetic flags kept
// - subtract-borrow: dst minus src minus carry, 32..36
// - subtract-borrow carry flags borrow; zero, sign follow result
// - subtract-borrow overflow: opposite signs, result matches source
// - subtract-borrow sets D; H set on nibble borrow
// - byte counts and 4/6 cycle timing per form
// - opcode DF forces carry, other flags kept
// - D0/D1 arithmetic right shift, bit 0 to carry
// - shift flags: C, Z, S set; V cleared
// - opcode 31 low bits pick one window pointer
// - low bits 00 load both, bit 3 split
// - opcode 7F stops clocks, no flag change
// - stop mode keeps every register's contents
// - only reset or external interrupt leaves stop
// - plain subtract 22..26: dst minus src
// - plain subtract overflow rule as with borrow
// - plain subtract sets D; H marks nibble borrow
// - opcode 4F clears bank flag only
module cpu_sub_shift_ptr
  import cpu_sub_pkg::*;
#(
  parameter bit BANK1_PRESENT = 1'b1
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic ce,
  input wire logic op_valid,
  input wire logic [7:0] opcode,
  input wire logic [7:0] dst_operand,
  input wire logic [7:0] src_operand,
  input wire logic ext_wake,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic op_ready,
  output logic [7:0] result_data,
  output logic result_we,
  output logic [1:0] instr_bytes,
  output logic [2:0] instr_cycles,
  output logic op_unsupported,
  output logic [7:0] flags,
  output logic [7:0] window_pointer_zero,
  output logic [7:0] window_pointer_one,
  output logic set1_bank_sel,
  output logic stop_mode,
  output logic clocks_run
);

  run_state_t state_reg;
  run_state_t state_next;
  logic [2:0] count_reg;
  logic [2:0] count_next;
  logic [7:0] flags_reg;
  logic [7:0] flags_next;
  logic [7:0] flags_hw;
  logic [7:0] ptr0_reg;
  logic [7:0] ptr0_next;
  logic [7:0] ptr1_reg;
  logic [7:0] ptr1_next;
  logic [7:0] result_reg;
  logic result_we_reg;
  logic [1:0] bytes_reg;
  logic [2:0] cycles_reg;
  logic unsupported_reg;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;

  alu_if alu_bus ();

  sub_shift_alu u_alu (
    .a(alu_bus.alu)
  );

  // operand hand-off to the arithmetic unit; carry comes from the live flags
  assign alu_bus.opcode = opcode;
  assign alu_bus.dst = dst_operand;
  assign alu_bus.src = src_operand;
  assign alu_bus.carry_in = flags_reg[FLAG_C];

  // opcode decode
  wire [3:0] opc_hi = opcode[7:4];
  wire [3:0] opc_form = opcode[3:0];
  wire form_ok = (opc_form >= FORM_FIRST) && (opc_form <= FORM_LAST);
  wire is_sub = (opc_hi == OPC_HI_SUB) && form_ok;
  wire is_sbc = (opc_hi == OPC_HI_SUB_BORROW) && form_ok;
  wire is_arith = is_sub || is_sbc;
  wire is_shift = (opcode == OPC_SHIFT_REG) || (opcode == OPC_SHIFT_IND);
  wire is_lower_bank = (opcode == OPC_SELECT_LOWER_BANK);
  wire is_upper_bank = (opcode == OPC_SELECT_UPPER_BANK);
  wire is_force_carry = (opcode == OPC_FORCE_CARRY);
  wire is_set_window = (opcode == OPC_SET_WINDOW);
  wire is_stop = (opcode == OPC_STOP);
  wire is_known = is_arith || is_shift || is_lower_bank || is_upper_bank ||
    is_force_carry || is_set_window || is_stop;

  // of the subtract forms, only the two-register and register-indirect ones are two bytes long
  wire arith_short_len = (opc_form == FORM_FIRST) || (opc_form == FORM_REG_IND);
  wire one_byte = is_lower_bank || is_upper_bank || is_force_carry || is_stop;
  wire [1:0] len_dec = !is_known ? BYTES_ONE :
    one_byte ? BYTES_ONE :
    (is_arith && !arith_short_len) ? BYTES_THREE : BYTES_TWO;

  // of the subtract forms only the working-register pair runs in four cycles; every other known opcode takes four too
  wire [2:0] cyc_dec = !is_known ? CYC_NONE :
    (is_arith && (opc_form != FORM_FIRST)) ? CYC_LONG : CYC_SHORT;

  // a request is only taken while idle; stop and busy both hold it off
  assign op_ready = (state_reg == ST_READY);
  wire accept = op_valid && op_ready;
  wire writes_result = accept && (is_arith || is_shift);

  // run state: busy covers the remaining cycles of the instruction
  // op_ready ignores ce, so the sequencer must not present a request while ce is low
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_READY: begin
        if (accept && is_stop) begin
          state_next = ST_STOPPED;
        end else if (accept && (cyc_dec > CYC_NONE)) begin
          state_next = ST_BUSY;
        end
      end
      ST_BUSY: begin
        if (count_reg == 3'h0) begin
          state_next = ST_READY;
        end
      end
      ST_STOPPED: begin
        // nothing inside the block restarts the clocks; only the wake line or srst
        if (ext_wake) begin
          state_next = ST_READY;
        end
      end
      default: begin
        state_next = ST_READY;
      end
    endcase
  end

  // one less than the cycles left after the accepting one; busy lasts count+1 cycles
  assign count_next = (accept && (cyc_dec > CYC_NONE)) ? 3'(cyc_dec - 3'h2) :
    (count_reg != 3'h0) ? 3'(count_reg - 3'h1) : 3'h0;

  // flag update per instruction class; untouched bits pass through
  always_comb begin
    flags_hw = flags_reg;
    case (1'b1)
      is_arith: begin
        flags_hw[FLAG_C] = alu_bus.c;
        flags_hw[FLAG_Z] = alu_bus.z;
        flags_hw[FLAG_S] = alu_bus.s;
        flags_hw[FLAG_V] = alu_bus.v;
        flags_hw[FLAG_D] = 1'b1;
        flags_hw[FLAG_H] = alu_bus.h;
      end
      is_shift: begin
        flags_hw[FLAG_C] = alu_bus.c;
        flags_hw[FLAG_Z] = alu_bus.z;
        flags_hw[FLAG_S] = alu_bus.s;
        flags_hw[FLAG_V] = 1'b0;
      end
      is_force_carry: begin
        flags_hw[FLAG_C] = 1'b1;
      end
      is_upper_bank: begin
        flags_hw[FLAG_BANK] = 1'b1;
      end
      is_lower_bank: begin
        flags_hw[FLAG_BANK] = 1'b0;
      end
      default: begin
        flags_hw = flags_reg; // stop and pointer-set leave flags alone
      end
    endcase
  end

  // register port writes are refused while stopped so stored state stays put
  wire sw_wr = reg_wr && (state_reg != ST_STOPPED);
  wire wr_flags = sw_wr && (reg_addr == REG_FLAGS);
  wire wr_ptr0 = sw_wr && (reg_addr == REG_PTR0);
  wire wr_ptr1 = sw_wr && (reg_addr == REG_PTR1);

  // an instruction in the same cycle as a software write wins
  assign flags_next = accept ? flags_hw : wr_flags ? reg_wdata : flags_reg;

  // pointer-set: source bits 1:0 pick the target pointer
  wire [1:0] ptr_sel = src_operand[1:0];
  wire set_ptr0_only = accept && is_set_window && (ptr_sel == 2'h2);
  wire set_ptr1_only = accept && is_set_window && (ptr_sel == 2'h1);
  wire set_both = accept && is_set_window && (ptr_sel == 2'h0);

  // the pair load keeps the two windows eight registers apart via bit 3
  wire [7:0] ptr0_pair = {src_operand[7:4], 1'b0, ptr0_reg[2:0]};
  wire [7:0] ptr1_pair = {src_operand[7:4], 1'b1, ptr1_reg[2:0]};
  wire [7:0] ptr0_single = {src_operand[7:PTR_SPLIT_BIT], ptr0_reg[2:0]};
  wire [7:0] ptr1_single = {src_operand[7:PTR_SPLIT_BIT], ptr1_reg[2:0]};

  // pattern 11 matches none of the loads and so leaves both pointers as they are
  assign ptr0_next = set_ptr0_only ? ptr0_single :
    set_both ? ptr0_pair :
    (wr_ptr0 && !(accept && is_set_window)) ? reg_wdata : ptr0_reg;
  assign ptr1_next = set_ptr1_only ? ptr1_single :
    set_both ? ptr1_pair :
    (wr_ptr1 && !(accept && is_set_window)) ? reg_wdata : ptr1_reg;

  // status word: run state plus the length and timing of the last instruction
  wire [7:0] status_word = {(state_reg == ST_STOPPED), (state_reg == ST_BUSY),
    1'b0, bytes_reg, cycles_reg};

  // read selection; unmapped offsets read as zero
  assign rdata_next = !reg_rd ? 8'h00 :
    (reg_addr == REG_FLAGS) ? flags_reg :
    (reg_addr == REG_PTR0) ? ptr0_reg :
    (reg_addr == REG_PTR1) ? ptr1_reg :
    (reg_addr == REG_STATUS) ? status_word : 8'h00;

  // control state; clock enable low freezes everything
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state_reg <= ST_READY;
      count_reg <= 3'h0;
    end else if (ce) begin
      state_reg <= state_next;
      count_reg <= count_next;
    end
  end

  // architectural registers: flags and the two window pointers
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      flags_reg <= FLAGS_RST;
      ptr0_reg <= PTR0_RST;
      ptr1_reg <= PTR1_RST;
    end else if (ce) begin
      flags_reg <= flags_next;
      ptr0_reg <= ptr0_next;
      ptr1_reg <= ptr1_next;
    end
  end

  // result hand-back to the sequencer: write strobe is one cycle long
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      result_reg <= 8'h00;
      result_we_reg <= 1'b0;
    end else if (ce) begin
      result_we_reg <= writes_result;
      if (writes_result) begin
        result_reg <= alu_bus.result;
      end
    end
  end

  // length and timing of the last accepted instruction, held for the fetch logic
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      bytes_reg <= BYTES_ONE;
      cycles_reg <= CYC_NONE;
      unsupported_reg <= 1'b0;
    end else if (ce) begin
      unsupported_reg <= accept && !is_known;
      if (accept) begin
        bytes_reg <= len_dec;
        cycles_reg <= cyc_dec;
      end
    end
  end

  // read data stand for exactly one cycle after the strobe
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rdata_reg <= 8'h00;
    end else if (ce) begin
      rdata_reg <= rdata_next;
    end
  end

  // output drive
  assign reg_rdata = rdata_reg;
  assign result_data = result_reg;
  assign result_we = result_we_reg;
  assign instr_bytes = bytes_reg;
  assign instr_cycles = cycles_reg;
  assign op_unsupported = unsupported_reg;
  assign flags = flags_reg;
  assign window_pointer_zero = ptr0_reg;
  assign window_pointer_one = ptr1_reg;

  // a part without the second bank still records the flag but decodes bank 0
  assign set1_bank_sel = flags_reg[FLAG_BANK] & BANK1_PRESENT;

  // clock gate request for the clock unit; the wake reset timing is the
  // caller's job, this block only relies on srst being clean when it lifts
  assign stop_mode = (state_reg == ST_STOPPED);
  assign clocks_run = !stop_mode;

endmodule : cpu_sub_shift_ptr

// *** verification/cpu_sub_shift_ptr_properties.sv ***
`timescale 1ns/10ps
module cpu_sub_shift_ptr_properties (
  input logic clk_sys,
  input logic srst,
  input logic ce,
  input logic op_valid,
  input logic [7:0] opcode,
  input logic [7:0] dst_operand,
  input logic [7:0] src_operand,
  input logic ext_wake,
  input logic op_ready,
  input logic [7:0] result_data,
  input logic result_we,
  input logic [1:0] instr_bytes,
  input logic [2:0] instr_cycles,
  input logic [7:0] flags,
  input logic [7:0] window_pointer_zero,
  input logic [7:0] window_pointer_one,
  input logic stop_mode
);
  // decode of the accepted request; forms 2..6 of both subtract groups
  wire acc = op_valid && op_ready && ce;
  wire sub_any = opcode[7:5] == 3'h1 && opcode[3:0] >= 4'h2 && opcode[3:0] <= 4'h6;
  logic [7:0] d_q, s_q, f_q;
  // copies of the accept cycle, since the answer shows one cycle later
  always_ff @(posedge clk_sys) begin
    d_q <= dst_operand;
    s_q <= src_operand;
    f_q <= flags;
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  property p_upper; acc && opcode == 8'h5f |=> flags == (f_q | 8'h01); endproperty
  a_upper: assert property (p_upper) else $error("upper bank flag wrong");
  property p_sub;
    acc && sub_any && !opcode[4] |=> result_we && result_data == d_q - s_q;
  endproperty
  a_sub: assert property (p_sub) else $error("subtract result wrong");
  property p_sbc;
    acc && sub_any && opcode[4] |=> result_data == d_q - s_q - f_q[7] && flags[3];
  endproperty
  a_sbc: assert property (p_sbc) else $error("borrow subtract wrong");
  property p_short;
    acc && sub_any && opcode[3:0] == 4'h2 |=>
      (instr_cycles == 3'h4 && !op_ready) [*3] ##1 op_ready;
  endproperty
  a_short: assert property (p_short) else $error("short form timing wrong");
  property p_long;
    acc && sub_any && opcode[3:0] != 4'h2 |=>
      (instr_cycles == 3'h6 && !op_ready) [*5] ##1 op_ready;
  endproperty
  a_long: assert property (p_long) else $error("long form timing wrong");
  property p_shift;
    acc && opcode[7:1] == 7'h68 |=> result_data == {d_q[7], d_q[7:1]} && flags[7] == d_q[0]
      && !flags[4] && flags[3:2] == f_q[3:2];
  endproperty
  a_shift: assert property (p_shift) else $error("shift wrong");
  property p_ptr;
    acc && opcode == 8'h31 && src_operand[1:0] == 2'h0 |=> flags == f_q
      && window_pointer_zero[7:3] == {s_q[7:4], 1'b0}
      && window_pointer_one[7:3] == {s_q[7:4], 1'b1};
  endproperty
  a_ptr: assert property (p_ptr) else $error("pointer pair load wrong");
  property p_force; acc && opcode == 8'hdf |=> flags == (f_q | 8'h80); endproperty
  a_force: assert property (p_force) else $error("carry force wrong");
  property p_stop; acc && opcode == 8'h7f |=> stop_mode && !op_ready && flags == f_q; endproperty
  a_stop: assert property (p_stop) else $error("stop entry wrong");
  property p_keep;
    stop_mode && !ext_wake |=> stop_mode && $stable(flags) && $stable(window_pointer_zero);
  endproperty
  a_keep: assert property (p_keep) else $error("stop state lost");
  property p_wake; stop_mode && ext_wake |=> !stop_mode && op_ready; endproperty
  a_wake: assert property (p_wake) else $error("wake failed");
endmodule : cpu_sub_shift_ptr_properties

bind cpu_sub_shift_ptr cpu_sub_shift_ptr_properties cpu_sub_shift_ptr_properties_i (.clk_sys,
  .srst, .ce, .op_valid, .opcode, .dst_operand, .src_operand, .ext_wake, .op_ready, .result_data,
  .result_we, .instr_bytes, .instr_cycles, .flags, .window_pointer_zero, .window_pointer_one,
  .stop_mode);

// *** verification/seq_model.sv ***
`timescale 1ns/10ps
// stands in for the fetch and sequencing logic that feeds resolved operands
module seq_model (
  input wire logic clk_sys,
  input wire logic op_ready,
  output logic op_valid,
  output logic [7:0] opcode,
  output logic [7:0] dst_operand,
  output logic [7:0] src_operand
);
  initial begin
    op_valid = 1'b0;
    opcode = 8'h00;
    dst_operand = 8'h00;
    src_operand = 8'h00;
  end
  // hold the request until taken, then invert the lines so stale values never look valid;
  // a request that is never taken is left to the bench watchdog
  task automatic issue(input logic [7:0] op, input logic [7:0] d, input logic [7:0] s, input int gap);
    repeat (gap + 1) @(posedge clk_sys);
    op_valid <= 1'b1;
    opcode <= op;
    dst_operand <= d;
    src_operand <= s;
    do begin
      @(posedge clk_sys);
    end while (op_ready !== 1'b1);
    op_valid <= 1'b0;
    opcode <= ~op;
    dst_operand <= ~d;
    src_operand <= ~s;
  endtask : issue
endmodule : seq_model

// *** verification/cpu_sub_shift_ptr_test.sv ***
`timescale 1ns/10ps
module cpu_sub_shift_ptr_test;
  import cpu_sub_pkg::*;
  logic clk_sys, srst, ce, ext_wake, reg_wr, reg_rd, op_valid, op_ready, result_we;
  logic op_unsupported, set1_bank_sel, stop_mode, clocks_run;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, result_data, flags, window_pointer_zero, window_pointer_one;
  logic [7:0] opcode, dst_operand, src_operand, ef, er;
  logic [1:0] instr_bytes;
  logic [2:0] instr_cycles;
  int n_fail, checks_done;
  logic [31:0] subs [10] = '{32'h32208a01, 32'h22120301, 32'h24219000, 32'h26216500,
    32'h33100301, 32'h34200301, 32'h35200a01, 32'h23210a00, 32'h25121200, 32'h36000001};
  logic [23:0] shf [3] = '{24'hd09a9c, 24'hd1bc9c, 24'hd00110};
  logic [23:0] fb [3] = '{24'hdffe00, 24'h5fff01, 24'h4ffe00};
  logic [23:0] ptr [4] = '{24'h404048, 24'h525048, 24'h695068, 24'hfb5068};

  cpu_sub_shift_ptr cpu_sub_shift_ptr_i (.clk_sys, .srst, .ce, .op_valid, .opcode, .dst_operand,
    .src_operand, .ext_wake, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .op_ready,
    .result_data, .result_we, .instr_bytes, .instr_cycles, .op_unsupported, .flags,
    .window_pointer_zero, .window_pointer_one, .set1_bank_sel, .stop_mode, .clocks_run);
  seq_model seq_model_i (.clk_sys, .op_ready, .op_valid, .opcode, .dst_operand, .src_operand);

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  task automatic cmp(input string nm, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : cmp
  task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : reg_write
  task automatic reg_read(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    cmp("reg_rdata", exp, reg_rdata);
  endtask : reg_read
  // flags and result of a borrow subtract, worked out bit by bit
  function automatic logic [15:0] sub_exp(input logic [7:0] d, input logic [7:0] s, input logic ci);
    logic [8:0] full;
    logic [4:0] low;
    full = {1'b0, d} - {1'b0, s} - 9'(ci);
    low = {1'b0, d[3:0]} - {1'b0, s[3:0]} - 5'(ci);
    return {full[8], full[7:0] == 8'h00, full[7], d[7] != s[7] && full[7] == s[7], 1'b1, low[4],
      2'b00, full[7:0]};
  endfunction : sub_exp
  task automatic print_verdict();
    if (n_fail == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : print_verdict

  // watchdog: the whole sequence needs well under a thousand cycles
  initial begin
    #20000;
    n_fail++;
    print_verdict();
  end

  // main sequence
  initial begin
    {srst, ce, ext_wake, reg_wr, reg_rd, reg_addr, reg_wdata} = {3'b110, 2'b00, 4'h0, 8'h00};
    n_fail = 0;
    checks_done = 0;
    repeat (8) @(posedge clk_sys);
    srst <= 1'b0;
    #1;
    cmp("flags", FLAGS_RST, flags);
    cmp("ptr0", PTR0_RST, window_pointer_zero);
    reg_read(REG_PTR1, PTR1_RST);
    foreach (subs[i]) begin
      reg_write(REG_FLAGS, {subs[i][0], 7'h00});
      seq_model_i.issue(subs[i][31:24], subs[i][23:16], subs[i][15:8], i % 3);
      #1;
      // plain subtract must ignore the carry that was written beforehand
      {ef, er} = sub_exp(subs[i][23:16], subs[i][15:8], subs[i][0] & subs[i][28]);
      cmp("result_data", er, result_data);
      cmp("flags", ef, flags);
      cmp("result_we", 8'h01, {7'h0, result_we});
      cmp("bytes", subs[i][27:24] < 4'h4 ? 8'h02 : 8'h03, {6'h0, instr_bytes});
      cmp("cycles", subs[i][27:24] == 4'h2 ? 8'h04 : 8'h06, {5'h0, instr_cycles});
    end
    foreach (shf[i]) begin
      reg_write(REG_FLAGS, shf[i][7:0]);
      #1;
      cmp("result_we", 8'h00, {7'h0, result_we});
      seq_model_i.issue(shf[i][23:16], shf[i][15:8], 8'h00, 0);
      #1;
      er = {shf[i][15], shf[i][15:9]};
      cmp("shift result", er, result_data);
      cmp("flags", {shf[i][8], er == 8'h00, er[7], 1'b0, shf[i][3:0]}, flags);
    end
    reg_write(REG_FLAGS, 8'h7e);
    foreach (fb[i]) begin
      seq_model_i.issue(fb[i][23:16], 8'h00, 8'h00, 0);
      #1;
      cmp("flags", fb[i][15:8], flags);
      cmp("bank_sel", fb[i][7:0], {7'h0, set1_bank_sel});
    end
    reg_read(REG_FLAGS, 8'hfe);
    reg_read(4'hf, 8'h00);
    reg_read(REG_STATUS, 8'h0c);
    foreach (ptr[i]) begin
      seq_model_i.issue(OPC_SET_WINDOW, 8'h00, ptr[i][23:16], 0);
      #1;
      cmp("ptr0", ptr[i][15:8], window_pointer_zero);
      cmp("ptr1", ptr[i][7:0], window_pointer_one);
      cmp("flags", 8'hfe, flags);
    end
    // a register write with the clock enable low must leave no trace
    @(posedge clk_sys);
    ce <= 1'b0;
    reg_write(REG_PTR0, 8'h11);
    ce <= 1'b1;
    #1;
    cmp("ptr0 frozen", 8'h50, window_pointer_zero);
    seq_model_i.issue(OPC_STOP, 8'h00, 8'h00, 0);
    #1;
    cmp("stop state", 8'h04, {5'h0, stop_mode, clocks_run, op_ready});
    reg_write(REG_FLAGS, 8'h00);
    reg_read(REG_FLAGS, 8'hfe);
    @(posedge clk_sys);
    ext_wake <= 1'b1;
    @(posedge clk_sys);
    ext_wake <= 1'b0;
    #1;
    cmp("woken", 8'h03, {5'h0, stop_mode, clocks_run, op_ready});
    seq_model_i.issue(OPC_STOP, 8'h00, 8'h00, 0);
    srst <= 1'b1;
    @(posedge clk_sys);
    srst <= 1'b0;
    #1;
    cmp("reset wake", 8'h03, {5'h0, stop_mode, clocks_run, op_ready});
    cmp("ptr1", PTR1_RST, window_pointer_one);
    seq_model_i.issue(8'h00, 8'h00, 8'h00, 0);
    #1;
    cmp("unsupported", 8'h03, {6'h0, op_unsupported, op_ready});
    print_verdict();
  end
endmodule : cpu_sub_shift_ptr_test
